//--- rtl/cmsp_clock_div.sv
// core clock tick generator: oscillator halving and 1..8 prescale
`timescale 1ns/1ps
`include "cmsp_defs.svh"
module cmsp_clock_div import cmsp_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic half_sel,
  input wire logic [2:0] prescale,
  output logic core_tick
);

  logic [3:0] cnt_reg;
  logic [3:0] limit;

  // total divide is (prescale+1) doubled when halving; limit is divide-1
  assign limit = half_sel ? {prescale, 1'b1} : {1'b0, prescale};

  // ----------------------------------------
  // divider counter
  // ----------------------------------------
  // a tick rather than a derived clock keeps everything on one clock tree
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cnt_reg <= 4'h0;
      core_tick <= 1'b0;
    end else if (cnt_reg >= limit) begin
      cnt_reg <= 4'h0;
      core_tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      core_tick <= 1'b0;
    end
  end

endmodule

//--- rtl/cmsp_defs.svh
// register offsets, field positions and reset values of the mode and stack pointer unit
`ifndef CMSP_DEFS_SVH
`define CMSP_DEFS_SVH

// ----------------------------------------
// register file locations (system group)
// ----------------------------------------
`define CMSP_MODE_ADDR 8'heb
`define CMSP_USP_HIGH_ADDR 8'hec
`define CMSP_USP_LOW_ADDR 8'hed
`define CMSP_SSP_HIGH_ADDR 8'hee
`define CMSP_SSP_LOW_ADDR 8'hef

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define CMSP_MODE_RESET 8'he0
`define CMSP_SSP_SEL_BIT 7
`define CMSP_USP_SEL_BIT 6
`define CMSP_HALF_BIT 5
`define CMSP_PRS_MSB 4
`define CMSP_PRS_LSB 2
`define CMSP_BUS_REQUEST_PIN_EN_BIT 1
`define CMSP_FLOAT_BIT 0

// ----------------------------------------
// stack engine sizes
// ----------------------------------------
`define CMSP_BUF_BYTES 5
`define CMSP_INT_HIGH 8'h00

`endif

//--- rtl/cmsp_mode_stack.sv
// cpu mode control register and system/user stack pointer engine
// Functional notes
// - mode bit 7: system stack internal/external
// - mode bit 6: user stack internal/external
// - mode bit 5 halves oscillator clock
// - mode bits 4:2 prescale core clock 1..8
// - mode bit 1 gates bus request pin
// - mode bit 0 floats external bus lines
// - float affects address/data configured lines and all control strobe lines
// - push pre-decrements, pop post-increments
// - pop leaves stack contents untouched
// - user and word variants, combinable
// - interrupt entry pushes pc and flags
// - code segment also pushed when enabled
// - call pushes pc; segment call adds segment
// - link reserves frame on selected stack
// - returns and unlink pop matching items
// - 16-bit pointers at consecutive system locations
// - internal stack uses low byte only
// - mode register resets to e0
`timescale 1ns/1ps
`include "cmsp_defs.svh"
module cmsp_mode_stack import cmsp_pkg::*; #(
  parameter int AD_W = 8,
  parameter bit HAS_BUS_REQUEST_PIN_PIN = 1'b1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic op_valid,
  input wire cmsp_op_type op_kind,
  input wire logic op_user,
  input wire logic op_word,
  input wire logic [15:0] op_data,
  input wire logic [15:0] op_pc,
  input wire logic [7:0] op_flags,
  input wire logic [7:0] op_cs,
  input wire logic [7:0] op_frame_len,
  input wire logic push_code_segment_en,
  output logic op_busy,
  output logic op_done,
  output logic [39:0] pop_data,
  output logic mem_rd,
  output logic mem_wr,
  output logic mem_ext,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic system_stack_location_sel,
  output logic user_stack_location_sel,
  output logic osc_half_rate_sel,
  output logic [2:0] core_clock_prescale,
  output logic ext_bus_float_en,
  output logic ext_bus_request_en,
  output logic core_clock_tick,
  input wire logic bus_request_pin,
  output logic ext_bus_request,
  input wire logic [AD_W-1:0] ad_drive_req,
  input wire logic [AD_W-1:0] ad_line_is_bus,
  output logic [AD_W-1:0] ad_oe_n,
  input wire logic [2:0] ctrl_drive_req,
  output logic [2:0] ctrl_oe_n
);

  logic [7:0] mode_reg;
  logic [15:0] usp_reg;
  logic [15:0] ssp_reg;
  cmsp_state_type state_reg;
  logic user_reg;
  logic [2:0] cnt_reg;
  logic [8*`CMSP_BUF_BYTES-1:0] buf_reg;
  logic [15:0] act_sp;
  logic act_internal;
  logic op_take;

  // pointer step: an internal stack only moves the low byte
  function automatic logic [15:0] sp_step(input logic [15:0] sp, input logic [15:0] delta,
                                          input logic internal);
    logic [15:0] sum;
    sum = sp + delta;
    sp_step = internal ? {sp[15:8], sum[7:0]} : sum;
  endfunction

  // stack address: register file stacks drop the high byte
  function automatic logic [15:0] stack_addr(input logic [15:0] sp, input logic internal);
    stack_addr = internal ? {`CMSP_INT_HIGH, sp[7:0]} : sp;
  endfunction

  // ----------------------------------------
  // decode of the active stack
  // ----------------------------------------
  assign act_sp = user_reg ? usp_reg : ssp_reg;
  assign act_internal = user_reg ? mode_reg[`CMSP_USP_SEL_BIT] : mode_reg[`CMSP_SSP_SEL_BIT];
  assign op_take = op_valid && !op_busy;

  assign system_stack_location_sel = mode_reg[`CMSP_SSP_SEL_BIT];
  assign user_stack_location_sel = mode_reg[`CMSP_USP_SEL_BIT];
  assign osc_half_rate_sel = mode_reg[`CMSP_HALF_BIT];
  assign core_clock_prescale = mode_reg[`CMSP_PRS_MSB:`CMSP_PRS_LSB];
  assign ext_bus_request_en = mode_reg[`CMSP_BUS_REQUEST_PIN_EN_BIT];
  assign ext_bus_float_en = mode_reg[`CMSP_FLOAT_BIT];

  // ----------------------------------------
  // mode register
  // ----------------------------------------
  // writes are held off while the engine runs so a stack never moves mid-operation
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mode_reg <= `CMSP_MODE_RESET;
    end else if (reg_wr && !op_busy && reg_addr == `CMSP_MODE_ADDR) begin
      mode_reg <= reg_wdata;
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        `CMSP_MODE_ADDR: reg_rdata <= mode_reg;
        `CMSP_USP_HIGH_ADDR: reg_rdata <= usp_reg[15:8];
        `CMSP_USP_LOW_ADDR: reg_rdata <= usp_reg[7:0];
        `CMSP_SSP_HIGH_ADDR: reg_rdata <= ssp_reg[15:8];
        `CMSP_SSP_LOW_ADDR: reg_rdata <= ssp_reg[7:0];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // stack pointers
  // ----------------------------------------
  // no reset: software must load them before the first stack operation
  always_ff @(posedge clock) begin
    if (reg_wr && !op_busy) begin
      unique case (reg_addr)
        `CMSP_USP_HIGH_ADDR: usp_reg[15:8] <= reg_wdata;
        `CMSP_USP_LOW_ADDR: usp_reg[7:0] <= reg_wdata;
        `CMSP_SSP_HIGH_ADDR: ssp_reg[15:8] <= reg_wdata;
        `CMSP_SSP_LOW_ADDR: ssp_reg[7:0] <= reg_wdata;
        default: ;
      endcase
    end
    if (op_take && (op_kind == CMSP_OP_LINK || op_kind == CMSP_OP_UNLINK)) begin
      // frame reserve or release, on the user stack in the user variant
      if (op_user) begin
        usp_reg <= sp_step(usp_reg, op_kind == CMSP_OP_LINK ? -{8'h00, op_frame_len} : {8'h00, op_frame_len},
                           mode_reg[`CMSP_USP_SEL_BIT]);
      end else begin
        ssp_reg <= sp_step(ssp_reg, op_kind == CMSP_OP_LINK ? -{8'h00, op_frame_len} : {8'h00, op_frame_len},
                           mode_reg[`CMSP_SSP_SEL_BIT]);
      end
    end else if (state_reg == CMSP_PUSH || state_reg == CMSP_POP) begin
      // push decrements before the write, pop increments after the read
      if (user_reg) begin
        usp_reg <= sp_step(usp_reg, state_reg == CMSP_PUSH ? 16'hffff : 16'h0001, act_internal);
      end else begin
        ssp_reg <= sp_step(ssp_reg, state_reg == CMSP_PUSH ? 16'hffff : 16'h0001, act_internal);
      end
    end
  end

  // ----------------------------------------
  // stack engine sequencing
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg <= CMSP_IDLE;
      op_busy <= 1'b0;
      op_done <= 1'b0;
      user_reg <= 1'b0;
      cnt_reg <= 3'h0;
      buf_reg <= '0;
    end else begin
      op_done <= 1'b0;
      unique case (state_reg)
        CMSP_IDLE: begin
          if (op_take) begin
            // automatic pushes always go to the system stack
            user_reg <= op_user && (op_kind == CMSP_OP_PUSH || op_kind == CMSP_OP_POP);
            unique case (op_kind)
              CMSP_OP_PUSH: begin
                buf_reg <= {24'h000000, op_data};
                cnt_reg <= op_word ? 3'd2 : 3'd1;
                state_reg <= CMSP_PUSH;
                op_busy <= 1'b1;
              end
              CMSP_OP_IRQ: begin
                // order pc low, pc high, [segment], flags
                buf_reg <= push_code_segment_en ? {8'h00, op_flags, op_cs, op_pc} : {16'h0000, op_flags, op_pc};
                cnt_reg <= push_code_segment_en ? 3'd4 : 3'd3;
                state_reg <= CMSP_PUSH;
                op_busy <= 1'b1;
              end
              CMSP_OP_CALL, CMSP_OP_CALLS: begin
                buf_reg <= {16'h0000, op_cs, op_pc};
                cnt_reg <= op_kind == CMSP_OP_CALLS ? 3'd3 : 3'd2;
                state_reg <= CMSP_PUSH;
                op_busy <= 1'b1;
              end
              CMSP_OP_POP, CMSP_OP_RET, CMSP_OP_RETS, CMSP_OP_IRET: begin
                // pop counts mirror what the matching entry pushed
                if (op_kind == CMSP_OP_POP) begin
                  cnt_reg <= op_word ? 3'd2 : 3'd1;
                end else if (op_kind == CMSP_OP_RET) begin
                  cnt_reg <= 3'd2;
                end else if (op_kind == CMSP_OP_RETS) begin
                  cnt_reg <= 3'd3;
                end else begin
                  cnt_reg <= push_code_segment_en ? 3'd4 : 3'd3;
                end
                state_reg <= CMSP_POP;
                op_busy <= 1'b1;
              end
              default: begin
                op_done <= 1'b1; // link and unlink finish in one cycle
              end
            endcase
          end
        end
        CMSP_PUSH: begin
          buf_reg <= {8'h00, buf_reg[8*`CMSP_BUF_BYTES-1:8]};
          cnt_reg <= cnt_reg - 3'd1;
          if (cnt_reg == 3'd1) begin
            state_reg <= CMSP_IDLE;
            op_busy <= 1'b0;
            op_done <= 1'b1;
          end
        end
        CMSP_POP: begin
          cnt_reg <= cnt_reg - 3'd1;
          if (cnt_reg == 3'd1) begin
            state_reg <= CMSP_DRAIN;
          end
        end
        CMSP_DRAIN: begin
          state_reg <= CMSP_IDLE;
          op_busy <= 1'b0;
          op_done <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // memory strobes
  // ----------------------------------------
  // reads never write back, so popped locations keep their bytes
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_ext <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      mem_wr <= state_reg == CMSP_PUSH;
      mem_rd <= state_reg == CMSP_POP;
      mem_ext <= !act_internal;
      mem_wdata <= buf_reg[7:0];
      if (state_reg == CMSP_PUSH) begin
        mem_addr <= stack_addr(sp_step(act_sp, 16'hffff, act_internal), act_internal);
      end else if (state_reg == CMSP_POP) begin
        mem_addr <= stack_addr(act_sp, act_internal);
      end
    end
  end

  // ----------------------------------------
  // pop result capture
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pop_data <= 40'h0000000000;
    end else if (op_take) begin
      pop_data <= 40'h0000000000;
    end else if (mem_rd) begin
      pop_data <= {pop_data[31:0], mem_rdata};
    end
  end

  // ----------------------------------------
  // external bus controls
  // ----------------------------------------
  // floating applies to lines configured as address/data and to all control strobes; plain i/o address lines still drive
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ad_oe_n <= '1;
      ctrl_oe_n <= 3'b111;
      ext_bus_request <= 1'b0;
    end else begin
      ad_oe_n <= ~(ad_drive_req & ~({AD_W{ext_bus_float_en}} & ad_line_is_bus));
      ctrl_oe_n <= ~(ctrl_drive_req & {3{!ext_bus_float_en}});
      ext_bus_request <= HAS_BUS_REQUEST_PIN_PIN && ext_bus_request_en && bus_request_pin;
    end
  end

  cmsp_clock_div u_clock_div (
    .clock(clock),
    .resetn(resetn),
    .half_sel(osc_half_rate_sel),
    .prescale(core_clock_prescale),
    .core_tick(core_clock_tick)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  mode_reset_a: assert property (@(posedge clock) !resetn |=> mode_reg == `CMSP_MODE_RESET)
    else $error("mode register not e0 after reset");
  push_predec_a: assert property (@(posedge clock) disable iff (!resetn)
    mem_wr |-> mem_addr[7:0] == act_sp[7:0])
    else $error("push address is not the decremented pointer");
  pop_postinc_a: assert property (@(posedge clock) disable iff (!resetn)
    mem_rd |-> mem_addr[7:0] == act_sp[7:0] - 8'h01)
    else $error("pop did not increment after reading");
  pop_nowrite_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_reg == CMSP_POP || state_reg == CMSP_DRAIN) |=> !mem_wr)
    else $error("write seen during a pop");
  internal_addr_a: assert property (@(posedge clock) disable iff (!resetn)
    ((mem_rd || mem_wr) && !mem_ext) |-> mem_addr[15:8] == 8'h00)
    else $error("internal stack address uses the high byte");
  irq_cs_a: assert property (@(posedge clock) disable iff (!resetn)
    (op_take && op_kind == CMSP_OP_IRQ && push_code_segment_en) |-> ##2 mem_wr [*4] ##0 op_done)
    else $error("interrupt entry with segment did not push four bytes");
  irq_plain_a: assert property (@(posedge clock) disable iff (!resetn)
    (op_take && op_kind == CMSP_OP_IRQ && !push_code_segment_en) |-> ##4 op_done ##0 $past(mem_wr, 2))
    else $error("interrupt entry did not push three bytes");
  call_push_a: assert property (@(posedge clock) disable iff (!resetn)
    (op_take && op_kind == CMSP_OP_CALL && !op_user) |-> ##3 op_done)
    else $error("call did not push two bytes");
  ret_pop_a: assert property (@(posedge clock) disable iff (!resetn)
    (op_take && op_kind == CMSP_OP_RET) |-> ##2 mem_rd [*2] ##1 op_done)
    else $error("return did not pop two bytes");
  link_once_a: assert property (@(posedge clock) disable iff (!resetn)
    (op_take && op_kind == CMSP_OP_LINK) |=> op_done && !op_busy)
    else $error("link did not finish in one cycle");
  float_gate_a: assert property (@(posedge clock) disable iff (!resetn)
    $past(resetn) |-> ad_oe_n == ~($past(ad_drive_req) & ~({AD_W{$past(mode_reg[0])}} & $past(ad_line_is_bus))))
    else $error("bus float gating wrong");
  bus_request_pin_gate_a: assert property (@(posedge clock) disable iff (!resetn)
    (!ext_bus_request_en || !bus_request_pin) |=> !ext_bus_request)
    else $error("bus request passed while disabled");

endmodule

//--- rtl/cmsp_pkg.sv
// types shared by the mode and stack pointer unit
package cmsp_pkg;

  // sequencer stack operations
  typedef enum logic [3:0] {
    CMSP_OP_PUSH = 4'h0,
    CMSP_OP_POP = 4'h1,
    CMSP_OP_IRQ = 4'h2,
    CMSP_OP_CALL = 4'h3,
    CMSP_OP_CALLS = 4'h4,
    CMSP_OP_LINK = 4'h5,
    CMSP_OP_UNLINK = 4'h6,
    CMSP_OP_RET = 4'h7,
    CMSP_OP_RETS = 4'h8,
    CMSP_OP_IRET = 4'h9
  } cmsp_op_type;

  // stack engine states, gray along idle-push and pop-drain-idle; idle-pop flips both bits
  typedef enum logic [1:0] {
    CMSP_IDLE = 2'b00,
    CMSP_PUSH = 2'b01,
    CMSP_POP = 2'b11,
    CMSP_DRAIN = 2'b10
  } cmsp_state_type;

endpackage

//--- verif/cmsp_mem_model.sv
// register file and external memory answering the stack engine's byte strobes
`timescale 1ns/1ps
module cmsp_mem_model (
  input wire logic clock,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic mem_ext,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] int_mem [256];
  logic [7:0] ext_mem [65536];
  logic [7:0] last_reg;
  int bad_high;

  // combinational answer; off a read the bus shows the inverse of the last byte,
  // so a late sample in the engine cannot pass by luck
  always_comb begin
    if (!mem_rd) mem_rdata = ~last_reg;
    else if (mem_ext) mem_rdata = ext_mem[mem_addr];
    else mem_rdata = int_mem[mem_addr[7:0]];
  end

  initial bad_high = 0;
  initial last_reg = 8'h00;
  // stores land at the edge that closes the strobe cycle
  always @(posedge clock) begin
    if (mem_rd) last_reg <= mem_rdata;
    if (mem_wr && mem_ext) ext_mem[mem_addr] <= mem_wdata;
    if (mem_wr && !mem_ext) int_mem[mem_addr[7:0]] <= mem_wdata;
    if ((mem_rd || mem_wr) && !mem_ext && mem_addr[15:8] != 8'h00) bad_high++;
  end
endmodule

//--- verif/cpu_mode_and_stack_pointer_unit_bench.sv
// self-checking bench for the mode register and stack pointer engine
`timescale 1ns/1ps
`include "cmsp_defs.svh"
module cpu_mode_and_stack_pointer_unit_bench import cmsp_pkg::*; ;
  // ----------------------------------------
  // signals and case tables
  // ----------------------------------------
  logic clock, resetn, reg_wr, op_valid, op_user, op_word, push_code_segment_en, op_busy, op_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, op_flags, op_cs, op_frame_len, mem_wdata, mem_rdata;
  logic mem_rd, mem_wr, mem_ext, system_stack_location_sel, user_stack_location_sel, osc_half_rate_sel;
  logic ext_bus_float_en, ext_bus_request_en, core_clock_tick, bus_request_pin, ext_bus_request;
  logic [15:0] op_data, op_pc, mem_addr;
  logic [39:0] pop_data;
  logic [2:0] core_clock_prescale, ctrl_drive_req, ctrl_oe_n;
  logic [7:0] ad_drive_req, ad_line_is_bus, ad_oe_n, mode_out, rv;
  logic [31:0] w32;
  logic [3:0] lat;
  cmsp_op_type op_kind;
  int miscompares, n_compared, ticks;
  typedef struct {cmsp_op_type k; logic [2:0] v; logic [3:0] lat; logic [39:0] pd; logic [7:0] sp;} cmsp_row_type;
  // {user, word, segment}, latency, popped bytes, pointer low byte after; sys starts c0, user 80
  cmsp_row_type rows [16] = '{
    '{CMSP_OP_PUSH, 3'h2, 4'h3, 40'h0, 8'hbe},
    '{CMSP_OP_POP, 3'h2, 4'h4, 40'hbeef, 8'hc0},
    '{CMSP_OP_PUSH, 3'h4, 4'h2, 40'h0, 8'h7f},
    '{CMSP_OP_POP, 3'h4, 4'h3, 40'hef, 8'h80},
    '{CMSP_OP_IRQ, 3'h0, 4'h4, 40'h0, 8'hbd},
    '{CMSP_OP_IRET, 3'h0, 4'h5, 40'h561234, 8'hc0},
    '{CMSP_OP_IRQ, 3'h1, 4'h5, 40'h0, 8'hbc},
    '{CMSP_OP_IRET, 3'h1, 4'h6, 40'h569a1234, 8'hc0},
    '{CMSP_OP_CALL, 3'h0, 4'h3, 40'h0, 8'hbe},
    '{CMSP_OP_RET, 3'h0, 4'h4, 40'h1234, 8'hc0},
    '{CMSP_OP_CALLS, 3'h0, 4'h4, 40'h0, 8'hbd},
    '{CMSP_OP_RETS, 3'h0, 4'h5, 40'h9a1234, 8'hc0},
    '{CMSP_OP_LINK, 3'h0, 4'h1, 40'h0, 8'hb0},
    '{CMSP_OP_UNLINK, 3'h0, 4'h1, 40'h0, 8'hc0},
    '{CMSP_OP_LINK, 3'h4, 4'h1, 40'h0, 8'h70},
    '{CMSP_OP_UNLINK, 3'h4, 4'h1, 40'h0, 8'h80}
  };
  // each divide figure below splits a 48-cycle window evenly
  logic [7:0] modes [6] = '{8'h1f, 8'ha5, 8'h4a, 8'h28, 8'h00, 8'he0};

  assign mode_out = {system_stack_location_sel, user_stack_location_sel, osc_half_rate_sel,
                     core_clock_prescale, ext_bus_request_en, ext_bus_float_en};

  always #2 clock = ~clock;

  cmsp_mode_stack #(.AD_W(8), .HAS_BUS_REQUEST_PIN_PIN(1'b1)) i_dut (
    .clock, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .op_valid, .op_kind, .op_user,
    .op_word, .op_data, .op_pc, .op_flags, .op_cs, .op_frame_len, .push_code_segment_en, .op_busy,
    .op_done, .pop_data, .mem_rd, .mem_wr, .mem_ext, .mem_addr, .mem_wdata, .mem_rdata,
    .system_stack_location_sel, .user_stack_location_sel, .osc_half_rate_sel, .core_clock_prescale,
    .ext_bus_float_en, .ext_bus_request_en, .core_clock_tick, .bus_request_pin, .ext_bus_request,
    .ad_drive_req, .ad_line_is_bus, .ad_oe_n, .ctrl_drive_req, .ctrl_oe_n
  );

  cmsp_mem_model i_mem (
    .clock, .mem_rd, .mem_wr, .mem_ext, .mem_addr, .mem_wdata, .mem_rdata
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude();
    $display("comparisons %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // inputs move on the falling edge, away from the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  // read data is registered, so it is taken one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    @(negedge clock);
    d = reg_rdata;
  endtask

  // one-cycle request, then a bounded wait for the done pulse; lat counts cycles after the take
  task automatic do_op(input cmsp_row_type r, output logic [3:0] l);
    @(negedge clock);
    op_kind = r.k;
    {op_user, op_word, push_code_segment_en} = r.v;
    op_valid = 1'b1;
    @(negedge clock);
    op_valid = 1'b0;
    // the first look falls on the falling edge half a cycle after the take edge, so a one-cycle op reads as 1
    l = 4'hf;
    for (int i = 1; i < 15 && l == 4'hf; i++) begin
      if (op_done === 1'b1) l = i[3:0];
      else @(negedge clock);
    end
    if (l == 4'hf) begin
      chk(1'b0, 1'b1, "stack op never finished");
      conclude();
    end
    chk(op_busy, 1'b0, "busy still high at done");
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    {reg_wr, op_valid, op_user, op_word, push_code_segment_en} = 5'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    op_kind = CMSP_OP_PUSH;
    op_data = 16'hbeef;
    op_pc = 16'h1234;
    op_flags = 8'h56;
    op_cs = 8'h9a;
    op_frame_len = 8'h10;
    bus_request_pin = 1'b1;
    ad_drive_req = 8'hff;
    ad_line_is_bus = 8'h0f;
    ctrl_drive_req = 3'h7;
    repeat (16) @(negedge clock);
    chk(mode_out, 8'he0, "mode in reset");
    resetn = 1'b1;
    // mode register fields, pin gating and clock division
    foreach (modes[i]) begin
      wr(`CMSP_MODE_ADDR, modes[i]);
      repeat (16) @(negedge clock);
      chk(mode_out, modes[i], "mode fields");
      chk(ad_oe_n, modes[i][0] ? 8'h0f : 8'h00, "address line enables");
      chk(ctrl_oe_n, modes[i][0] ? 3'h7 : 3'h0, "strobe enables");
      chk(ext_bus_request, modes[i][1], "bus request");
      rd(`CMSP_MODE_ADDR, rv);
      chk(rv, modes[i], "mode readback");
      ticks = 0;
      repeat (48) begin
        @(negedge clock);
        ticks += int'(core_clock_tick === 1'b1);
      end
      chk(ticks, 48 / ((modes[i][4:2] + 1) * (modes[i][5] ? 2 : 1)), "tick count");
    end
    // stacks in groups 8 and c stay inside the first 14 groups
    // only register file stacks in use until the external stack runs, so the external bus is floated
    wr(`CMSP_MODE_ADDR, 8'he1);
    wr(`CMSP_USP_HIGH_ADDR, 8'h00);
    wr(`CMSP_USP_LOW_ADDR, 8'h80);
    wr(`CMSP_SSP_HIGH_ADDR, 8'h12);
    wr(`CMSP_SSP_LOW_ADDR, 8'hc0);
    foreach (rows[i]) begin
      do_op(rows[i], lat);
      chk(lat, rows[i].lat, "op latency");
      chk(pop_data, rows[i].pd, "popped bytes");
      rd(rows[i].v[2] ? `CMSP_USP_LOW_ADDR : `CMSP_SSP_LOW_ADDR, rv);
      chk(rv, rows[i].sp, "pointer low byte");
      w32 = {i_mem.int_mem[8'hbf], i_mem.int_mem[8'hbe], i_mem.int_mem[8'hbd], i_mem.int_mem[8'hbc]};
      if (i == 7) chk(w32, 32'h34129a56, "stacked bytes after return");
    end
    // internal pointer wraps in its low byte only
    wr(`CMSP_SSP_LOW_ADDR, 8'h01);
    do_op(rows[0], lat);
    rd(`CMSP_SSP_LOW_ADDR, rv);
    chk(rv, 8'hff, "wrapped pointer");
    rd(`CMSP_SSP_HIGH_ADDR, rv);
    chk(rv, 8'h12, "reserved high byte");
    chk({i_mem.int_mem[8'h00], i_mem.int_mem[8'hff]}, 16'hefbe, "wrapped bytes");
    chk(i_mem.bad_high, 40'h0, "register file upper address");
    // external system stack borrows into the high byte
    wr(`CMSP_MODE_ADDR, 8'h60);
    wr(`CMSP_SSP_HIGH_ADDR, 8'h10);
    wr(`CMSP_SSP_LOW_ADDR, 8'h00);
    do_op(rows[0], lat);
    // the last byte lands one edge after done, so read back first
    rd(`CMSP_SSP_HIGH_ADDR, rv);
    chk({i_mem.ext_mem[16'h0fff], i_mem.ext_mem[16'h0ffe]}, 16'hefbe, "external push");
    chk(rv, 8'h0f, "pointer borrow");
    // external user stack
    wr(`CMSP_MODE_ADDR, 8'ha0);
    wr(`CMSP_USP_HIGH_ADDR, 8'h20);
    wr(`CMSP_USP_LOW_ADDR, 8'h00);
    do_op(rows[2], lat);
    rd(8'hf0, rv);
    chk(i_mem.ext_mem[16'h1fff], 8'hef, "external user push");
    chk(rv, 8'h00, "unmapped read");
    // a second reset in mid-run restores the mode register
    resetn = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    rd(`CMSP_MODE_ADDR, rv);
    chk(rv, 8'he0, "mode after second reset");
    conclude();
  end
endmodule
